//--- compact_timer_defines.vh
// register offsets, field positions, reset values and timing counts of the compact timer
`ifndef COMPACT_TIMER_DEFINES_VH
`define COMPACT_TIMER_DEFINES_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define OFS_CTRL_CLOCK_PERIOD 12'h000
`define OFS_CTRL_MODE_OUTPUT 12'h004
`define OFS_COUNTER_LOW 12'h008
`define OFS_COUNTER_HIGH 12'h00C
`define OFS_FINE_COMPARE_LOW 12'h010
`define OFS_FINE_COMPARE_HIGH 12'h014
`define OFS_MATCH_FLAGS 12'h018

// ----------------------------------------
// control register 0 fields
// ----------------------------------------
`define BIT_PAUSE 7
`define CKSEL_HI 6
`define CKSEL_LO 4
`define BIT_COUNTER_ON 3
`define RP_HI 2
`define RP_LO 0

// ----------------------------------------
// control register 1 fields
// ----------------------------------------
`define MODE_HI 7
`define MODE_LO 6
`define IO_HI 5
`define IO_LO 4
`define BIT_OUT_INIT 3
`define BIT_POL 2
`define BIT_SWAP 1
`define BIT_CLR_SRC 0

// ----------------------------------------
// encodings
// ----------------------------------------
`define MODE_COMPARE 2'h0
`define MODE_PWM 2'h2
`define MODE_TIMER 2'h3
`define IO_NONE 2'h0
`define IO_LOW 2'h1
`define IO_HIGH 2'h2
`define IO_TOGGLE 2'h3
`define CK_SYS_DIV4 3'h0
`define CK_SYS 3'h1
`define CK_HIGH_DIV16 3'h2
`define CK_HIGH_DIV64 3'h3
`define CK_EXT_RISE 3'h6
`define CK_EXT_FALL 3'h7

// ----------------------------------------
// reset values and dividers
// ----------------------------------------
`define CTRL_RESET 8'h00
`define SYS_DIV 4
`define HIGH_DIV16 16
`define HIGH_DIV64 64
`define SUB_DIV_DEFAULT 305

`endif

//--- compact_timer_module.v
// compact 10-bit timer with coarse and fine comparators behind an apb slave

`include "compact_timer_defines.vh"

module compact_timer_module #(
	parameter CNT_W = 10,
	parameter SUB_DIV = `SUB_DIV_DEFAULT
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire external_count_input,
	input wire high_clk_tick,
	output reg timer_output_pin,
	output reg timer_output_enable,
	output reg fine_match_flag,
	output reg coarse_match_flag
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] ctrl0_reg;
reg [7:0] ctrl1_reg;
reg [CNT_W-1:0] count_reg;
reg [CNT_W-1:0] fine_cmp_reg;
reg [7:0] low_buf_reg;
reg [1:0] flag_sticky_reg;
reg on_prev_reg;
reg ext_prev_reg;
reg out_raw_reg;

// ----------------------------------------
// control field decode
// ----------------------------------------
wire pause_control = ctrl0_reg[`BIT_PAUSE];
wire [2:0] clock_source_select = ctrl0_reg[`CKSEL_HI:`CKSEL_LO];
wire counter_on_control = ctrl0_reg[`BIT_COUNTER_ON];
wire [2:0] coarse_period_value = ctrl0_reg[`RP_HI:`RP_LO];
wire [1:0] operating_mode_field = ctrl1_reg[`MODE_HI:`MODE_LO];
wire [1:0] pin_action_field = ctrl1_reg[`IO_HI:`IO_LO];
wire output_initial_level = ctrl1_reg[`BIT_OUT_INIT];
wire output_polarity_invert = ctrl1_reg[`BIT_POL];
wire period_duty_swap = ctrl1_reg[`BIT_SWAP];
wire clear_source_select = ctrl1_reg[`BIT_CLR_SRC];
wire is_compare = (operating_mode_field == `MODE_COMPARE);
wire is_pwm = (operating_mode_field == `MODE_PWM);

// ----------------------------------------
// clock source ticks
// ----------------------------------------
wire sys_div_tick;
wire high16_tick;
wire high64_tick;
wire sub_tick;

// separate prescalers; the /16 and /64 taps stay aligned since both reset together
tick_prescaler #(
	.W(2),
	.LAST(`SYS_DIV - 1)
) sys_div_u (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.step_en(1'b1),
	.tick(sys_div_tick)
);

tick_prescaler #(
	.W(4),
	.LAST(`HIGH_DIV16 - 1)
) high16_u (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.step_en(high_clk_tick),
	.tick(high16_tick)
);

tick_prescaler #(
	.W(6),
	.LAST(`HIGH_DIV64 - 1)
) high64_u (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.step_en(high_clk_tick),
	.tick(high64_tick)
);

// sub clock is only a plain divider of the system clock here
tick_prescaler #(
	.W(16),
	.LAST(SUB_DIV - 1)
) sub_u (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.step_en(1'b1),
	.tick(sub_tick)
);

// previous pin level for the external edge detector; idles low like the pin
always @(posedge clk_sys) begin
	if (sys_rst)
		ext_prev_reg <= 1'b0;
	else
		ext_prev_reg <= external_count_input;
end

reg tick;
always @* begin
	case (clock_source_select)
	`CK_SYS_DIV4: tick = sys_div_tick;
	`CK_SYS: tick = 1'b1;
	`CK_HIGH_DIV16: tick = high16_tick;
	`CK_HIGH_DIV64: tick = high64_tick;
	`CK_EXT_RISE: tick = external_count_input && !ext_prev_reg;
	`CK_EXT_FALL: tick = !external_count_input && ext_prev_reg;
	default: tick = sub_tick;
	endcase
end

// ----------------------------------------
// comparators and clear decision
// ----------------------------------------
wire on_rise = counter_on_control && !on_prev_reg;
wire running = counter_on_control && !pause_control && tick;
// match is judged on the value the counter reaches after this tick
wire [CNT_W-1:0] count_inc = count_reg + 10'h001;
wire coarse_hit = (coarse_period_value != 3'h0) &&
	(count_inc[9:7] == coarse_period_value) && (count_inc[6:0] == 7'h00);
wire fine_hit = (fine_cmp_reg != 10'h000) && (count_inc == fine_cmp_reg);
wire wrap = (count_reg == 10'h3FF);
wire coarse_period_end = (coarse_period_value == 3'h0) ? wrap : coarse_hit;
wire fine_period_end = (fine_cmp_reg == 10'h000) ? wrap : fine_hit;
reg clear_now;
always @* begin
	if (is_pwm)
		clear_now = period_duty_swap ? fine_period_end : coarse_period_end;
	else
		clear_now = clear_source_select ? fine_period_end : coarse_period_end;
end
wire fine_flag_ev = running && fine_hit;
wire coarse_flag_ev = running && coarse_period_end && !(!is_pwm && clear_source_select);

// ----------------------------------------
// counter
// ----------------------------------------
always @(posedge clk_sys) begin
	if (sys_rst) begin
		count_reg <= 10'h000;
		on_prev_reg <= 1'b0;
	end else begin
		on_prev_reg <= counter_on_control;
		// restart clear outranks a tick landing in the same cycle
		if (on_rise)
			count_reg <= 10'h000;
		else if (running)
			count_reg <= clear_now ? 10'h000 : count_inc;
	end
end

// ----------------------------------------
// match request pulses
// ----------------------------------------
always @(posedge clk_sys) begin
	if (sys_rst) begin
		fine_match_flag <= 1'b0;
		coarse_match_flag <= 1'b0;
	end else begin
		fine_match_flag <= fine_flag_ev;
		coarse_match_flag <= coarse_flag_ev;
	end
end

// ----------------------------------------
// output pin
// ----------------------------------------
// pwm active while counter is below the duty threshold
wire [CNT_W:0] period_len = {1'b0, coarse_period_value, 7'h00};
wire [CNT_W:0] coarse_len = (coarse_period_value == 3'h0) ? 11'h400 : period_len;
wire [CNT_W:0] fine_len = (fine_cmp_reg == 10'h000) ? 11'h400 : {1'b0, fine_cmp_reg};
wire [CNT_W:0] duty_len = period_duty_swap ? coarse_len : {1'b0, fine_cmp_reg};
wire [CNT_W:0] per_len = period_duty_swap ? fine_len : coarse_len;
wire pwm_active = (duty_len >= per_len) || ({1'b0, count_reg} < duty_len);
reg out_level;
always @* begin
	case (pin_action_field)
	`IO_NONE: out_level = !output_initial_level;
	`IO_LOW: out_level = output_initial_level;
	`IO_HIGH: out_level = pwm_active ? output_initial_level : !output_initial_level;
	default: out_level = !output_initial_level;
	endcase
end

always @(posedge clk_sys) begin
	if (sys_rst) begin
		out_raw_reg <= 1'b0;
	end else begin
		if (is_compare) begin
			if (on_rise)
				out_raw_reg <= output_initial_level;
			else if (fine_flag_ev) begin
				case (pin_action_field)
				`IO_LOW: out_raw_reg <= 1'b0;
				`IO_HIGH: out_raw_reg <= 1'b1;
				`IO_TOGGLE: out_raw_reg <= !out_raw_reg;
				default: out_raw_reg <= out_raw_reg;
				endcase
			end
		end else if (is_pwm) begin
			out_raw_reg <= on_rise ? output_initial_level : out_level;
		end
	end
end

// ----------------------------------------
// pin drivers
// ----------------------------------------
// polarity sits after the raw level so it never disturbs the waveform state
always @(posedge clk_sys) begin
	if (sys_rst) begin
		timer_output_pin <= 1'b0;
		timer_output_enable <= 1'b0;
	end else begin
		// timer mode releases the pin; 01 mode also left undriven
		timer_output_enable <= is_compare || is_pwm;
		timer_output_pin <= out_raw_reg ^ output_polarity_invert;
	end
end

// ----------------------------------------
// apb slave, one wait state
// ----------------------------------------
wire acc = psel && penable && !pready;
wire wr = acc && pwrite;
wire rd = acc && !pwrite;
reg [31:0] rdata_next;
reg addr_ok;
always @* begin
	rdata_next = 32'h00000000;
	addr_ok = 1'b1;
	case (paddr)
	`OFS_CTRL_CLOCK_PERIOD: rdata_next[7:0] = ctrl0_reg;
	`OFS_CTRL_MODE_OUTPUT: rdata_next[7:0] = ctrl1_reg;
	`OFS_COUNTER_LOW: rdata_next[7:0] = low_buf_reg;
	`OFS_COUNTER_HIGH: rdata_next[1:0] = count_reg[9:8];
	`OFS_FINE_COMPARE_LOW: rdata_next[7:0] = low_buf_reg;
	`OFS_FINE_COMPARE_HIGH: rdata_next[1:0] = fine_cmp_reg[9:8];
	`OFS_MATCH_FLAGS: rdata_next[1:0] = flag_sticky_reg;
	default: addr_ok = 1'b0;
	endcase
end

// ----------------------------------------
// bus response, one cycle after the access is taken
// ----------------------------------------
always @(posedge clk_sys) begin
	if (sys_rst) begin
		prdata <= 32'h00000000;
		pready <= 1'b0;
		pslverr <= 1'b0;
	end else begin
		pready <= acc;
		pslverr <= acc && !addr_ok;
		prdata <= rd ? rdata_next : 32'h00000000;
	end
end

// ----------------------------------------
// sticky match flags
// ----------------------------------------
// write-one-to-clear, but a new event wins over the clear
wire flag_clr_hit = wr && (paddr == `OFS_MATCH_FLAGS);
wire [1:0] flag_clear = flag_clr_hit ? pwdata[1:0] : 2'h0;
wire [1:0] flag_set = {coarse_flag_ev, fine_flag_ev};

always @(posedge clk_sys) begin
	if (sys_rst)
		flag_sticky_reg <= 2'h0;
	else
		flag_sticky_reg <= (flag_sticky_reg & ~flag_clear) | flag_set;
end

// ----------------------------------------
// register file and shared low-byte buffer
// ----------------------------------------
always @(posedge clk_sys) begin
	if (sys_rst) begin
		ctrl0_reg <= `CTRL_RESET;
		ctrl1_reg <= `CTRL_RESET;
		fine_cmp_reg <= 10'h000;
		low_buf_reg <= 8'h00;
	end else begin
		if (wr) begin
			case (paddr)
			`OFS_CTRL_CLOCK_PERIOD: ctrl0_reg <= pwdata[7:0];
			`OFS_CTRL_MODE_OUTPUT: ctrl1_reg <= pwdata[7:0];
			`OFS_FINE_COMPARE_LOW: low_buf_reg <= pwdata[7:0];
			`OFS_FINE_COMPARE_HIGH: fine_cmp_reg <= {pwdata[1:0], low_buf_reg};
			default: ;
			endcase
		end else if (rd) begin
			if (paddr == `OFS_COUNTER_HIGH)
				low_buf_reg <= count_reg[7:0];
			else if (paddr == `OFS_FINE_COMPARE_HIGH)
				low_buf_reg <= fine_cmp_reg[7:0];
		end
	end
end

endmodule

// ----------------------------------------
// rate prescaler: one-cycle tick after LAST+1 enabled steps
// ----------------------------------------
module tick_prescaler #(
	parameter W = 2,
	parameter LAST = 3
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire step_en,
	output wire tick
);

localparam [W-1:0] LAST_W = LAST[W-1:0];
localparam [W-1:0] ONE_W = {{(W-1){1'b0}}, 1'b1};

reg [W-1:0] count_reg;

assign tick = step_en && (count_reg == LAST_W);

always @(posedge clk_sys) begin
	if (sys_rst)
		count_reg <= {W{1'b0}};
	else if (tick)
		count_reg <= {W{1'b0}};
	else if (step_en)
		count_reg <= count_reg + ONE_W;
end

endmodule

//--- compact_timer_asserts.sv
// concurrent checks on the compact timer ports
`include "compact_timer_defines.vh"
module compact_timer_asserts (
	input wire clk_sys,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire external_count_input,
	input wire high_clk_tick,
	input wire timer_output_pin,
	input wire timer_output_enable,
	input wire fine_match_flag,
	input wire coarse_match_flag
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	reg [7:0] mode_reg;
	wire take = psel && penable && !pready;
	wire mode_wr = psel && penable && pready && pwrite && paddr == `OFS_CTRL_MODE_OUTPUT;
	// ----------------------------------------
	// shadow of the mode register, one cycle late
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (sys_rst)
			mode_reg <= 8'h00;
		else if (mode_wr)
			mode_reg <= pwdata[7:0];
	end
	chk_answer_next: assert property (take |=> pready)
		else $error("no answer one cycle after access");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	chk_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read data or error outside answer cycle");
	chk_unmapped_err: assert property (take && paddr > `OFS_MATCH_FLAGS |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_byte_upper: assert property (take && !pwrite && paddr <= `OFS_FINE_COMPARE_HIGH
		|=> prdata[31:8] == 24'h0)
		else $error("register read beyond one byte");
	chk_high_bits: assert property (take && !pwrite && (paddr == `OFS_COUNTER_HIGH
		|| paddr == `OFS_FINE_COMPARE_HIGH) |=> prdata[31:2] == 30'h0)
		else $error("high byte shows unused bits");
	chk_timer_nopin: assert property (mode_wr && pwdata[7:6] == `MODE_TIMER |=> !timer_output_enable [*2])
		else $error("pin driven in timer mode");
	chk_pin_enabled: assert property (mode_wr && !pwdata[6] |=> timer_output_enable)
		else $error("pin not driven in compare or pwm mode");
	chk_no_coarse: assert property (mode_reg[0] && mode_reg[7:6] != `MODE_PWM
		&& $past(mode_reg, 4) == mode_reg |-> !coarse_match_flag)
		else $error("coarse flag with fine clear source");
endmodule
bind compact_timer_module compact_timer_asserts chk_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.external_count_input(external_count_input), .high_clk_tick(high_clk_tick),
	.timer_output_pin(timer_output_pin), .timer_output_enable(timer_output_enable),
	.fine_match_flag(fine_match_flag), .coarse_match_flag(coarse_match_flag));

//--- testbench.sv
// self-checking bench for the compact timer
`include "compact_timer_defines.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, ext_in = 0, hi_tick = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, v;
	logic pready, pslverr, pin, pin_en, ff, cf;
	logic [33:0] exp_q[$], ev;
	int mismatches = 0, n_checks = 0, seed = 40;
	integer nf, nc, nh;
	int per[8] = '{512, 128, 4096, 16384, 512, 512, 256, 256};
	int pwm_hi[3] = '{0, 1280, 320};
	compact_timer_module #(.SUB_DIV(4)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .external_count_input(ext_in),
		.high_clk_tick(hi_tick), .timer_output_pin(pin), .timer_output_enable(pin_en),
		.fine_match_flag(ff), .coarse_match_flag(cf));
	initial forever #50 clk_sys = ~clk_sys;
	// external pin rises every second cycle, high tick every second cycle
	always @(posedge clk_sys) begin
		ext_in <= ~ext_in;
		hi_tick <= ext_in;
	end
	task check(string what, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task report_and_stop;
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------
	// apb master: setup, access, hold until ready
	// ----------------------------------------
	task apb(logic [11:0] a, logic w, logic [31:0] d, logic err, logic [31:0] e);
		int n;
		@(posedge clk_sys);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		exp_q.push_back({w, err, e});
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			mismatches++;
			report_and_stop;
		end else begin
			{psel, penable} <= 2'b00;
		end
	endtask
	task wr(logic [11:0] a, logic [31:0] d);
		apb(a, 1'b1, d, 1'b0, 32'h0);
	endtask
	task rd(logic [11:0] a, logic [31:0] e);
		apb(a, 1'b0, 32'h0, 1'b0, e);
	endtask
	task fine(logic [9:0] f);
		wr(`OFS_FINE_COMPARE_LOW, {24'h0, f[7:0]});
		wr(`OFS_FINE_COMPARE_HIGH, {30'h0, f[9:8]});
	endtask
	task watch(int cyc);
		{nf, nc, nh} = 0;
		repeat (cyc) begin
			@(posedge clk_sys);
			nf += ff;
			nc += cf;
			nh += pin;
		end
	endtask
	// mode changes only while the counter is off
	task run(logic [7:0] c1, logic [7:0] c0, int settle);
		wr(`OFS_CTRL_CLOCK_PERIOD, 32'h0);
		wr(`OFS_CTRL_MODE_OUTPUT, {24'h0, c1});
		wr(`OFS_CTRL_CLOCK_PERIOD, {24'h0, c0});
		watch(settle);
	endtask
	always @(posedge clk_sys) begin
		if (pready === 1'b1) begin
			ev = exp_q.pop_front();
			check("pslverr", {31'h0, pslverr}, {31'h0, ev[32]});
			if (!ev[33])
				check("prdata", prdata, ev[31:0]);
		end
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int a = 0; a < 28; a += 4)
			rd(12'(a), 32'h0);
		apb(12'h020, 1'b1, 32'h5A, 1'b1, 32'h0);
		apb(12'h01C, 1'b0, 32'h0, 1'b1, 32'h0);
		v = $random(seed);
		wr(`OFS_CTRL_MODE_OUTPUT, {24'h0, v[7:0]});
		rd(`OFS_CTRL_MODE_OUTPUT, {24'h0, v[7:0]});
		v = $random(seed);
		fine(v[9:0]);
		rd(`OFS_FINE_COMPARE_HIGH, {30'h0, v[9:8]});
		rd(`OFS_FINE_COMPARE_LOW, {24'h0, v[7:0]});
		fine(10'd40);
		run(8'h30, 8'h19, 200);
		watch(1280);
		check("coarse flags", nc, 10);
		check("fine flags", nf, 10);
		check("toggled pin high", nh, 640);
		check("pin enable", {31'h0, pin_en}, 32'h1);
		wr(`OFS_CTRL_CLOCK_PERIOD, 32'h11);
		watch(400);
		check("flags while off", nc + nf, 0);
		run(8'h38, 8'h19, 4);
		watch(20);
		check("initial level", nh, 20);
		run(8'h3C, 8'h19, 4);
		watch(20);
		check("inverted level", nh, 0);
		wr(`OFS_CTRL_CLOCK_PERIOD, 32'h99);
		watch(400);
		check("flags while paused", nc, 0);
		wr(`OFS_CTRL_CLOCK_PERIOD, 32'h19);
		watch(1280);
		check("flags after resume", nc, 10);
		run(8'h31, 8'h19, 200);
		watch(1280);
		check("fine clear flags", nf, 32);
		check("coarse silent", nc, 0);
		fine(10'd0);
		run(8'h31, 8'h19, 200);
		watch(2048);
		check("zero fine flags", nf + nc, 0);
		fine(10'd32);
		for (int k = 0; k < 3; k++) begin
			run({2'b10, 2'(k), 4'h8}, 8'h19, 200);
			watch(1280);
			check("pwm high cycles", nh, pwm_hi[k]);
		end
		run(8'hAA, 8'h19, 200);
		watch(1280);
		check("full duty", nh, 1280);
		check("period clears", nf, 40);
		run(8'h30, 8'h18, 300);
		wr(`OFS_CTRL_CLOCK_PERIOD, 32'h98);
		rd(`OFS_COUNTER_HIGH, 32'h1);
		rd(`OFS_COUNTER_LOW, 32'h2F);
		run(8'hC0, 8'h19, 8);
		check("timer pin", {31'h0, pin_en}, 32'h0);
		for (int k = 0; k < 8; k++) begin
			run(8'h00, {1'b0, 3'(k), 4'h9}, per[k] / 2);
			watch(2 * per[k]);
			check("source period", nc, 2);
		end
		report_and_stop;
	end
endmodule
